// ===== hw/mpu_pkg.sv
// Shared constants and types of the multiprocessor serial unit and its peer
// Functional notes
// - Extra bit: 1 means ID, 0 means data
// - ID wait skips transfer, errors and flags
// - ID character sets rx_id_bit, clears wait
// - Accepted ID fills buffer, raises receive-full request
// - Multiprocessor format ignores parity enable
// - Transmitted extra bit follows tx_id_bit
// - Transmit buffer write clears tx_empty_flag
// - Receive buffer read clears rx_full_flag
// - Four requests from full, empty, done, faults
// - tx_empty_flag resets to one
// - tx_done_flag resets to one
// - Software enables transmit requests after writing data
// - Break sets framing fault, maybe parity fault
// - Break keeps setting framing fault after clear
// - Transmitter off: pin follows port direction, level
// - Clearing tx_on resets transmitter at once
// - Port direction and level one hold mark
// - Break send: direction one, level zero, then off
// - Synchronous mode: faults block transmit start
// - Clearing rx_on keeps fault flags
// - Receiver uses 16x clock, syncs on start edge
// - Bits latched at eighth basic-clock pulse
package mpu_pkg;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned MID_TICK   = 8;
    localparam int unsigned DATA_BITS  = 8;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned BAUD_W     = 16;
    localparam logic [15:0] BAUD_RST   = 16'h0015;
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_STAT   = 8'h04;
    localparam logic [7:0]  OFS_TXD    = 8'h08;
    localparam logic [7:0]  OFS_RXD    = 8'h0C;
    localparam logic [7:0]  OFS_BAUD   = 8'h10;
    localparam int unsigned CTRL_W     = 12;
    localparam int unsigned C_TX_ON    = 0;
    localparam int unsigned C_RX_ON    = 1;
    localparam int unsigned C_RX_IRQ   = 2;
    localparam int unsigned C_TE_IRQ   = 3;
    localparam int unsigned C_TD_IRQ   = 4;
    localparam int unsigned C_ID_WAIT  = 5;
    localparam int unsigned C_MP       = 6;
    localparam int unsigned C_PAR      = 7;
    localparam int unsigned C_PODD     = 8;
    localparam int unsigned C_SYNC     = 9;
    localparam int unsigned C_PDIR     = 10;
    localparam int unsigned C_PLVL     = 11;
    localparam logic [11:0] CTRL_RST   = 12'h000;
    localparam int unsigned S_TXE      = 7;
    localparam int unsigned S_RXF      = 6;
    localparam int unsigned S_OVR      = 5;
    localparam int unsigned S_FRM      = 4;
    localparam int unsigned S_PAR      = 3;
    localparam int unsigned S_TXD      = 2;
    localparam int unsigned S_RXID     = 1;
    localparam int unsigned S_TXID     = 0;
    localparam logic [7:0]  STAT_RST   = 8'h84;
    typedef enum logic [4:0] {
        FR_IDLE  = 5'h01,
        FR_START = 5'h02,
        FR_DATA  = 5'h04,
        FR_EXTRA = 5'h08,
        FR_STOP  = 5'h10
    } mpu_frame_type;
endpackage : mpu_pkg

// ===== hw/mpu_link_if.sv
// Shared serial line between the unit and a peer station
interface mpu_link_if;
    logic dev_tx_o;
    logic dev_tx_oe_n;
    logic peer_tx;
    logic dev_line;
    // Pull-up keeps the line at mark while the unit releases it
    assign dev_line = dev_tx_oe_n ? 1'b1 : dev_tx_o;
    modport dev  (output dev_tx_o, output dev_tx_oe_n, input peer_tx);
    modport peer (output peer_tx, input dev_line);
endinterface : mpu_link_if

// ===== hw/mpu_device.sv
// Multiprocessor serial unit with APB registers
//
// Register access over APB and the address map were left to the implementer.
module mpu_device (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             rx_full_irq,
    output logic             tx_empty_irq,
    output logic             tx_done_irq,
    output logic             rx_fault_irq,
    mpu_link_if.dev          link
);
    localparam logic [3:0] BIT_LAST = 4'(mpu_pkg::OVERSAMPLE - 1);
    localparam logic [3:0] MID_LAST = 4'(mpu_pkg::MID_TICK - 1);
    localparam logic [2:0] BIT_MSB  = 3'(mpu_pkg::DATA_BITS - 1);

    logic [11:0]  ctrl_reg;
    logic [7:0]   stat_reg;
    logic [15:0]  baud_reg;
    logic [15:0]  baud_cnt_reg;
    logic         tick_reg;
    logic [7:0]   tx_buffer_reg;
    logic [7:0]   rx_buffer_reg;
    logic [31:0]  prdata_reg;
    logic         pready_reg;
    logic         pslverr_reg;
    logic         acc;
    logic         wr_txd;
    logic         rd_rxd;
    logic         wr_stat;

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == mpu_pkg::OFS_CTRL) || (a == mpu_pkg::OFS_STAT) ||
                 (a == mpu_pkg::OFS_TXD)  || (a == mpu_pkg::OFS_RXD)  ||
                 (a == mpu_pkg::OFS_BAUD);
    endfunction : mapped

    assign acc     = psel & penable & pready_reg;
    assign wr_txd  = acc & pwrite & (paddr == mpu_pkg::OFS_TXD);
    assign rd_rxd  = acc & ~pwrite & (paddr == mpu_pkg::OFS_RXD);
    assign wr_stat = acc & pwrite & (paddr == mpu_pkg::OFS_STAT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= psel & ~penable;
            pslverr_reg <= psel & ~penable & ~mapped(paddr);
            if (psel & ~penable) begin
                unique case (paddr)
                    mpu_pkg::OFS_CTRL: prdata_reg <= 32'(ctrl_reg);
                    mpu_pkg::OFS_STAT: prdata_reg <= 32'(stat_reg);
                    mpu_pkg::OFS_RXD:  prdata_reg <= 32'(rx_buffer_reg);
                    mpu_pkg::OFS_BAUD: prdata_reg <= 32'(baud_reg);
                    default:           prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // 16x basic clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg <= (baud_cnt_reg == 16'h0000);
            if (baud_cnt_reg == 16'h0000) begin
                baud_cnt_reg <= baud_reg;
            end else begin
                baud_cnt_reg <= baud_cnt_reg - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    mpu_pkg::mpu_frame_type tx_st_reg;
    logic [3:0]   tx_cnt_reg;
    logic [2:0]   tx_bit_reg;
    logic [7:0]   tx_shifter;
    logic         tx_x_reg;
    logic         tx_xon_reg;
    logic         tx_load;
    logic         tx_end;
    logic         tx_level;
    logic         faults;

    assign faults  = stat_reg[mpu_pkg::S_OVR] | stat_reg[mpu_pkg::S_FRM] |
                     stat_reg[mpu_pkg::S_PAR];
    assign tx_load = ctrl_reg[mpu_pkg::C_TX_ON] & ~stat_reg[mpu_pkg::S_TXE] &
                     (tx_st_reg == mpu_pkg::FR_IDLE) & ~wr_txd &
                     ~(ctrl_reg[mpu_pkg::C_SYNC] & faults);
    assign tx_end  = (tx_st_reg == mpu_pkg::FR_STOP) & tick_reg &
                     (tx_cnt_reg == BIT_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_reg  <= mpu_pkg::FR_IDLE;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_shifter <= 8'h00;
            tx_x_reg   <= 1'b0;
            tx_xon_reg <= 1'b0;
        end else if (!ctrl_reg[mpu_pkg::C_TX_ON]) begin
            tx_st_reg  <= mpu_pkg::FR_IDLE;
            tx_cnt_reg <= 4'h0;
        end else if (tx_load) begin
            tx_st_reg  <= mpu_pkg::FR_START;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_shifter <= tx_buffer_reg;
            tx_xon_reg <= ctrl_reg[mpu_pkg::C_MP] | ctrl_reg[mpu_pkg::C_PAR];
            if (ctrl_reg[mpu_pkg::C_MP]) begin
                tx_x_reg <= stat_reg[mpu_pkg::S_TXID];
            end else begin
                tx_x_reg <= ^tx_buffer_reg ^ ctrl_reg[mpu_pkg::C_PODD];
            end
        end else if (tick_reg && tx_st_reg != mpu_pkg::FR_IDLE) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == BIT_LAST) begin
                unique case (tx_st_reg)
                    mpu_pkg::FR_START: tx_st_reg <= mpu_pkg::FR_DATA;
                    mpu_pkg::FR_DATA: begin
                        tx_shifter <= {1'b1, tx_shifter[7:1]};
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        if (tx_bit_reg == BIT_MSB) begin
                            tx_st_reg <= tx_xon_reg ? mpu_pkg::FR_EXTRA
                                                    : mpu_pkg::FR_STOP;
                        end
                    end
                    mpu_pkg::FR_EXTRA: tx_st_reg <= mpu_pkg::FR_STOP;
                    default:           tx_st_reg <= mpu_pkg::FR_IDLE;
                endcase
            end
        end
    end

    always_comb begin
        unique case (tx_st_reg)
            mpu_pkg::FR_START: tx_level = 1'b0;
            mpu_pkg::FR_DATA:  tx_level = tx_shifter[0];
            mpu_pkg::FR_EXTRA: tx_level = tx_x_reg;
            default:           tx_level = 1'b1;
        endcase
    end

    logic line_o_reg;
    logic line_oe_n_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_o_reg    <= 1'b1;
            line_oe_n_reg <= 1'b1;
        end else if (ctrl_reg[mpu_pkg::C_TX_ON]) begin
            line_o_reg    <= tx_level;
            line_oe_n_reg <= 1'b0;
        end else begin
            line_o_reg    <= ctrl_reg[mpu_pkg::C_PLVL];
            line_oe_n_reg <= ~ctrl_reg[mpu_pkg::C_PDIR];
        end
    end

    assign link.dev_tx_o    = line_o_reg;
    assign link.dev_tx_oe_n = line_oe_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    mpu_pkg::mpu_frame_type rx_st_reg;
    logic         rx_s1_reg;
    logic         rx_s2_reg;
    logic [3:0]   rx_cnt_reg;
    logic [2:0]   rx_bit_reg;
    logic [7:0]   rx_shifter;
    logic         rx_x_reg;
    logic         rx_done;
    logic         rx_skip;
    logic         rx_perr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= link.peer_tx;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_reg  <= mpu_pkg::FR_IDLE;
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_shifter <= 8'h00;
            rx_x_reg   <= 1'b0;
        end else if (!ctrl_reg[mpu_pkg::C_RX_ON]) begin
            rx_st_reg <= mpu_pkg::FR_IDLE;
        end else if (rx_st_reg == mpu_pkg::FR_IDLE) begin
            if (!rx_s2_reg) begin
                rx_st_reg  <= mpu_pkg::FR_START;
                rx_cnt_reg <= 4'h0;
            end
        end else if (tick_reg) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_st_reg == mpu_pkg::FR_START) begin
                if (rx_cnt_reg == MID_LAST) begin
                    rx_st_reg  <= rx_s2_reg ? mpu_pkg::FR_IDLE : mpu_pkg::FR_DATA;
                    rx_cnt_reg <= 4'h0;
                    rx_bit_reg <= 3'h0;
                end
            end else if (rx_cnt_reg == BIT_LAST) begin
                unique case (rx_st_reg)
                    mpu_pkg::FR_DATA: begin
                        rx_shifter <= {rx_s2_reg, rx_shifter[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == BIT_MSB) begin
                            rx_st_reg <= (ctrl_reg[mpu_pkg::C_MP] | ctrl_reg[mpu_pkg::C_PAR])
                                         ? mpu_pkg::FR_EXTRA : mpu_pkg::FR_STOP;
                        end
                    end
                    mpu_pkg::FR_EXTRA: begin
                        rx_x_reg  <= rx_s2_reg;
                        rx_st_reg <= mpu_pkg::FR_STOP;
                    end
                    default: rx_st_reg <= mpu_pkg::FR_IDLE;
                endcase
            end
        end
    end

    assign rx_done = ctrl_reg[mpu_pkg::C_RX_ON] & (rx_st_reg == mpu_pkg::FR_STOP) &
                     tick_reg & (rx_cnt_reg == BIT_LAST);
    assign rx_skip = ctrl_reg[mpu_pkg::C_MP] & ctrl_reg[mpu_pkg::C_ID_WAIT] &
                     ~rx_x_reg;
    assign rx_perr = ctrl_reg[mpu_pkg::C_PAR] & ~ctrl_reg[mpu_pkg::C_MP] &
                     (^rx_shifter ^ ctrl_reg[mpu_pkg::C_PODD] ^ rx_x_reg);

    ////////////////////////////////////////////////////////////////////////
    // Registers and flags; hardware sets win over software clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= mpu_pkg::CTRL_RST;
            baud_reg      <= mpu_pkg::BAUD_RST;
            tx_buffer_reg <= 8'h00;
        end else begin
            if (acc && pwrite && paddr == mpu_pkg::OFS_CTRL) begin
                ctrl_reg <= pwdata[11:0];
            end else if (rx_done && !rx_skip && ctrl_reg[mpu_pkg::C_MP] && rx_x_reg) begin
                ctrl_reg[mpu_pkg::C_ID_WAIT] <= 1'b0;
            end
            if (acc && pwrite && paddr == mpu_pkg::OFS_BAUD) begin
                baud_reg <= pwdata[15:0];
            end
            if (wr_txd) begin
                tx_buffer_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg      <= mpu_pkg::STAT_RST;
            rx_buffer_reg <= 8'h00;
        end else begin
            if (wr_stat) begin
                stat_reg[mpu_pkg::S_TXID] <= pwdata[mpu_pkg::S_TXID];
                stat_reg[mpu_pkg::S_OVR]  <= stat_reg[mpu_pkg::S_OVR] & pwdata[mpu_pkg::S_OVR];
                stat_reg[mpu_pkg::S_FRM]  <= stat_reg[mpu_pkg::S_FRM] & pwdata[mpu_pkg::S_FRM];
                stat_reg[mpu_pkg::S_PAR]  <= stat_reg[mpu_pkg::S_PAR] & pwdata[mpu_pkg::S_PAR];
            end
            if (wr_txd) begin
                stat_reg[mpu_pkg::S_TXE] <= 1'b0;
            end
            if (tx_load) begin
                stat_reg[mpu_pkg::S_TXE] <= 1'b1;
                stat_reg[mpu_pkg::S_TXD] <= 1'b0;
            end
            if (tx_end && stat_reg[mpu_pkg::S_TXE]) begin
                stat_reg[mpu_pkg::S_TXD] <= 1'b1;
            end
            if (rd_rxd) begin
                stat_reg[mpu_pkg::S_RXF] <= 1'b0;
            end
            if (rx_done && !rx_skip) begin
                if (!rx_s2_reg) begin
                    stat_reg[mpu_pkg::S_FRM] <= 1'b1;
                end
                if (stat_reg[mpu_pkg::S_RXF]) begin
                    stat_reg[mpu_pkg::S_OVR] <= 1'b1;
                end else begin
                    rx_buffer_reg            <= rx_shifter;
                    stat_reg[mpu_pkg::S_RXF] <= 1'b1;
                    if (rx_perr) begin
                        stat_reg[mpu_pkg::S_PAR] <= 1'b1;
                    end
                end
                if (ctrl_reg[mpu_pkg::C_MP]) begin
                    stat_reg[mpu_pkg::S_RXID] <= rx_x_reg;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests; rx_on clear leaves fault flags alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_irq  <= 1'b0;
            tx_empty_irq <= 1'b0;
            tx_done_irq  <= 1'b0;
            rx_fault_irq <= 1'b0;
        end else begin
            rx_full_irq  <= ctrl_reg[mpu_pkg::C_RX_IRQ] & stat_reg[mpu_pkg::S_RXF];
            tx_empty_irq <= ctrl_reg[mpu_pkg::C_TE_IRQ] & stat_reg[mpu_pkg::S_TXE];
            tx_done_irq  <= ctrl_reg[mpu_pkg::C_TD_IRQ] & stat_reg[mpu_pkg::S_TXD];
            rx_fault_irq <= ctrl_reg[mpu_pkg::C_RX_IRQ] & faults;
        end
    end
endmodule : mpu_device

// ===== hw/mpu_peer.sv
// Peer station sending and receiving multiprocessor-format characters
module mpu_peer #(
    parameter logic [15:0] DIV = mpu_pkg::BAUD_RST
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       send_valid,
    input  wire logic [7:0] send_data,
    input  wire logic       send_id,
    output logic            send_ready,
    output logic            recv_valid,
    output logic [7:0]      recv_data,
    output logic            recv_id,
    output logic            recv_fault,
    mpu_link_if.peer        link
);
    localparam logic [3:0] BIT_LAST = 4'(mpu_pkg::OVERSAMPLE - 1);
    localparam logic [3:0] MID_LAST = 4'(mpu_pkg::MID_TICK - 1);

    logic [15:0] div_reg;
    logic        tick_reg;
    logic [3:0]  tx_cnt_reg;
    logic [3:0]  tx_num_reg;
    logic [10:0] tx_frame_reg;
    logic        tx_busy_reg;
    logic        s1_reg;
    logic        s2_reg;
    logic        rx_busy_reg;
    logic [3:0]  rx_cnt_reg;
    logic [3:0]  rx_num_reg;
    logic [10:0] rx_frame_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 16'h0000);
            div_reg  <= (div_reg == 16'h0000) ? DIV : div_reg - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit: start, eight data bits, ID bit, stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_reg  <= 1'b0;
            tx_cnt_reg   <= 4'h0;
            tx_num_reg   <= 4'h0;
            tx_frame_reg <= 11'h7FF;
            send_ready   <= 1'b0;
        end else begin
            send_ready <= ~tx_busy_reg & ~(send_valid & send_ready);
            if (send_valid && send_ready) begin
                tx_busy_reg  <= 1'b1;
                tx_cnt_reg   <= 4'h0;
                tx_num_reg   <= 4'h0;
                tx_frame_reg <= {1'b1, send_id, send_data, 1'b0};
            end else if (tx_busy_reg && tick_reg) begin
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == BIT_LAST) begin
                    tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                    tx_num_reg   <= tx_num_reg + 4'h1;
                    if (tx_num_reg == 4'hA) begin
                        tx_busy_reg <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.peer_tx <= 1'b1;
        end else begin
            link.peer_tx <= tx_busy_reg ? tx_frame_reg[0] : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive, sampled at the bit centre
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            s1_reg <= link.dev_line;
            s2_reg <= s1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy_reg  <= 1'b0;
            rx_cnt_reg   <= 4'h0;
            rx_num_reg   <= 4'h0;
            rx_frame_reg <= 11'h000;
            recv_valid   <= 1'b0;
            recv_data    <= 8'h00;
            recv_id      <= 1'b0;
            recv_fault   <= 1'b0;
        end else begin
            recv_valid <= 1'b0;
            if (!rx_busy_reg) begin
                if (!s2_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_cnt_reg  <= 4'h0;
                    rx_num_reg  <= 4'h0;
                end
            end else if (tick_reg) begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                if ((rx_num_reg == 4'h0) ? (rx_cnt_reg == MID_LAST)
                                         : (rx_cnt_reg == BIT_LAST)) begin
                    rx_cnt_reg   <= 4'h0;
                    rx_num_reg   <= rx_num_reg + 4'h1;
                    rx_frame_reg <= {s2_reg, rx_frame_reg[10:1]};
                    if (rx_num_reg == 4'h0 && s2_reg) begin
                        rx_busy_reg <= 1'b0;
                    end
                    if (rx_num_reg == 4'hA) begin
                        rx_busy_reg <= 1'b0;
                        recv_valid  <= 1'b1;
                        recv_data   <= rx_frame_reg[9:2];
                        recv_id     <= rx_frame_reg[10];
                        recv_fault  <= ~s2_reg;
                    end
                end
            end
        end
    end
endmodule : mpu_peer

// ===== verif/mpu_link_props.sv
// Assertions on the bus and the shared serial line
module mpu_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dev_line,
    input wire logic peer_tx,
    input wire logic send_valid,
    input wire logic send_ready,
    input wire logic recv_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    chk_peer_bit: assert property ($fell(peer_tx) |-> !peer_tx [*8])
        else $error("short low bit");
    chk_dev_bit: assert property ($fell(dev_line) |-> !dev_line [*8])
        else $error("short low bit on device");
    chk_recv_pulse: assert property (recv_valid |=> !recv_valid)
        else $error("recv_valid held");
    chk_send_take: assert property (send_valid && send_ready |=> !send_ready)
        else $error("send not taken");
    chk_peer_mark: assert property (send_ready |-> peer_tx)
        else $error("idle line not mark");
    cover property ($rose(recv_valid));
    cover property (pslverr);
    cover property ($fell(dev_line));
endmodule : mpu_link_props

// ===== verif/testbench.sv
// Self-checking bench for the serial unit and its peer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00, send_data = 8'h00, recv_data, d;
    logic [31:0] pwdata = 32'h0, prdata, rd, s = 32'h604B;
    logic        pready, pslverr, rx_full_irq, tx_empty_irq, tx_done_irq, rx_fault_irq;
    logic        send_valid = 0, send_id = 0, send_ready, recv_valid, recv_id, recv_fault;
    int          fail_count = 0, cmp_count = 0;
    logic [8:0]  exp_q[$];
    mpu_link_if link ();
    mpu_device i_mpu_device (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_full_irq, .tx_empty_irq, .tx_done_irq,
        .rx_fault_irq, .link(link.dev));
    mpu_peer i_mpu_peer (.pclk, .presetn, .send_valid, .send_data, .send_id, .send_ready,
        .recv_valid, .recv_data, .recv_id, .recv_fault, .link(link.peer));
    mpu_link_props i_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
        .dev_line(link.dev_line), .peer_tx(link.peer_tx), .send_valid, .send_ready,
        .recv_valid);
    ////////////////////
    initial forever #12.5 pclk = ~pclk;
    function automatic logic [7:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[7:0];
    endfunction : rnd
    task chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task apb(logic w, logic [7:0] a, logic [31:0] v);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    task psend(logic [7:0] v, logic i);
        send_data <= v; send_id <= i; send_valid <= 1;
        do @(posedge pclk); while (send_ready !== 1'b1);
        send_valid <= 0;
        do @(posedge pclk); while (send_ready !== 1'b1);
        repeat (4) @(posedge pclk);
    endtask : psend
    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, mpu_pkg::OFS_STAT, 0); chk("stat", 32'h84, rd);
        apb(1, mpu_pkg::OFS_CTRL, 32'h18); @(posedge pclk);
        chk("irq", 32'h3, 32'({tx_empty_irq, tx_done_irq}));
        apb(0, 8'h20, 0); chk("slverr", 32'h1, 32'(err));
        for (int i = 0; i < 2; i++) begin
            d = rnd(); exp_q.push_back({i[0], d});
            apb(1, mpu_pkg::OFS_CTRL, 32'h40); apb(1, mpu_pkg::OFS_STAT, 32'(i));
            apb(1, mpu_pkg::OFS_TXD, 32'(d));
            apb(0, mpu_pkg::OFS_STAT, 0); chk("txe", 32'h0, 32'(rd[7]));
            apb(1, mpu_pkg::OFS_CTRL, 32'h48); @(posedge pclk);
            chk("early", 32'h0, 32'(tx_empty_irq));
            apb(1, mpu_pkg::OFS_CTRL, 32'h49);
            do @(posedge pclk); while (recv_valid !== 1'b1);
            chk("char", 32'(exp_q.pop_front()), 32'({recv_id, recv_data}));
            chk("txirq", 32'h1, 32'(tx_empty_irq));
        end
        apb(1, mpu_pkg::OFS_CTRL, 32'h66);
        psend(rnd(), 0); chk("skip", 32'h0, 32'(rx_full_irq));
        d = rnd(); psend(d, 1); chk("idirq", 32'h1, 32'(rx_full_irq));
        apb(0, mpu_pkg::OFS_CTRL, 0); chk("wait", 32'h46, rd);
        apb(0, mpu_pkg::OFS_STAT, 0); chk("rxid", 32'h3, 32'({rd[6], rd[1]}));
        apb(0, mpu_pkg::OFS_RXD, 0); chk("rxd", 32'(d), rd);
        apb(0, mpu_pkg::OFS_STAT, 0); chk("rxf", 32'h0, 32'(rd[6]));
        apb(1, mpu_pkg::OFS_CTRL, 32'h66);
        psend(rnd(), 0); chk("rearm", 32'h0, 32'(rx_full_irq));
        psend(d, 1); psend(rnd(), 0); chk("ovrirq", 32'h1, 32'(rx_fault_irq));
        apb(1, mpu_pkg::OFS_CTRL, 32'h44);
        apb(0, mpu_pkg::OFS_STAT, 0); chk("ovr", 32'h1, 32'(rd[5]));
        apb(1, mpu_pkg::OFS_TXD, 32'(rnd())); apb(1, mpu_pkg::OFS_CTRL, 32'h241);
        repeat (40) @(posedge pclk);
        apb(0, mpu_pkg::OFS_STAT, 0); chk("sync", 32'h0, 32'(rd[7]));
        apb(1, mpu_pkg::OFS_STAT, 0); repeat (400) @(posedge pclk);
        apb(1, mpu_pkg::OFS_CTRL, 32'h401); apb(1, mpu_pkg::OFS_CTRL, 32'h400);
        repeat (8) @(posedge pclk); chk("brk", 32'h0, 32'(link.dev_line));
        apb(1, mpu_pkg::OFS_CTRL, 32'hC00);
        repeat (2) @(posedge pclk); chk("mark", 32'h1, 32'(link.dev_line));
        test_done();
    end
endmodule : testbench
